/* File: hw/sfr_map_slice.sv */
/*
  Special register slice on an AXI4-Lite slave, with comparator
  flag and flash completion interrupts.
  Assumes one clock, flash status on that clock, async comparators.
*/
// What this block does
// - Reserved bits written zero, read as zero; flash status bits 6:4 read as one.
// - Fixed-zero bits always read back zero.
// - Fixed-one bits always read back one.
// - Flash control read returns busy and flags.
// - Flash control write is an 8-bit command.
// - Flash address high/low, high has two bits.
// - Baud divisor low and high bytes.
// - Baud control holds enable and source select.
// - Comparator one six-field control layout.
// - Comparator two uses the same layout.
// - Clock divider is a full byte.
// - Data pointer from high and low bytes.
// - Own address: seven bits plus general call.
`timescale 1ns/100ps
`include "sfr_map_params.svh"

module sfr_map_slice #(
  parameter int ADDR_W = 12
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_reset_n,
  input  wire logic                       i_s_axi_awvalid,
  output logic                            o_s_axi_awready,
  input  wire logic [ADDR_W-1:0]          i_s_axi_awaddr,
  input  wire logic                       i_s_axi_wvalid,
  output logic                            o_s_axi_wready,
  input  wire logic [31:0]                i_s_axi_wdata,
  input  wire logic [3:0]                 i_s_axi_wstrb,
  output logic                            o_s_axi_bvalid,
  input  wire logic                       i_s_axi_bready,
  output logic [1:0]                      o_s_axi_bresp,
  input  wire logic                       i_s_axi_arvalid,
  output logic                            o_s_axi_arready,
  input  wire logic [ADDR_W-1:0]          i_s_axi_araddr,
  output logic                            o_s_axi_rvalid,
  input  wire logic                       i_s_axi_rready,
  output logic [31:0]                     o_s_axi_rdata,
  output logic [1:0]                      o_s_axi_rresp,
  input  wire logic [1:0]                 i_cmp_level,
  input  wire sfr_map_pkg::flash_status_t i_flash_status,
  output sfr_map_pkg::flash_cmd_t         o_flash_cmd,
  output sfr_map_pkg::sfr_ctrl_t          o_ctrl,
  output logic                            o_irq
);

  // ==========================================
  // Elaboration check
  if (ADDR_W < 10) begin : g_bad_width
    $error("ADDR_W must cover ten address bits");
  end

  // ==========================================
  // Address decoding helpers
  // Upper address bits set make the location unmapped
  function automatic logic [8:0] word_of(
    input logic [ADDR_W-1:0] a);
    logic hi_zero;
    hi_zero = (a >> 10) == '0;
    return {hi_zero, a[9:2]};
  endfunction

  function automatic logic mapped(input logic [8:0] w);
    logic ok;
    ok = 1'b0;
    if (w[8]) begin
      case (w[7:0])
        `IX_DATA_PTR_LO, `IX_DATA_PTR_HI, `IX_CLOCK_DIV,
        `IX_AUX_CTL, `IX_CMP_ONE, `IX_CMP_TWO,
        `IX_BAUD_CTL, `IX_BAUD_LO, `IX_BAUD_HI,
        `IX_SBUS_CTL, `IX_SBUS_DATA, `IX_SBUS_ADDR,
        `IX_ACCUM, `IX_FLASH_CTL, `IX_FLASH_DATA,
        `IX_FLASH_ADR_LO, `IX_FLASH_ADR_HI, `IX_SECOND_OP,
        `IX_IRQ_STATUS, `IX_IRQ_MASK: ok = 1'b1;
        default: ok = 1'b0;
      endcase
    end
    return ok;
  endfunction

  // ==========================================
  // Bus state
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic [8:0]  aw_word_q;
  logic [7:0]  wbyte_q;
  logic        wlane_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [7:0]  rbyte_q;

  // Register state
  logic [7:0]  ptr_lo_q;
  logic [7:0]  ptr_hi_q;
  logic [7:0]  clk_div_q;
  logic [7:0]  aux_q;
  logic [7:0]  cmp_q [2];
  logic [7:0]  baud_ctl_q;
  logic [7:0]  baud_lo_q;
  logic [7:0]  baud_hi_q;
  logic [7:0]  sbus_ctl_q;
  logic [7:0]  sbus_data_q;
  logic [7:0]  sbus_addr_q;
  logic [7:0]  accum_q;
  logic [7:0]  fdata_q;
  logic [7:0]  fadr_lo_q;
  logic [7:0]  fadr_hi_q;
  logic [7:0]  second_q;
  logic [2:0]  irq_stat_q;
  logic [2:0]  irq_stat_d;
  logic [2:0]  irq_mask_q;
  logic        irq_q;
  sfr_map_pkg::flash_status_t fstat_q;
  sfr_map_pkg::flash_cmd_t    fcmd_q;

  // Comparator synchronisers
  logic [1:0]  cmp_s1_q;
  logic [1:0]  cmp_s2_q;
  logic [1:0]  cmp_prev_q;

  // ==========================================
  // Handshake decoding
  wire         aw_hs   = i_s_axi_awvalid & awready_q;
  wire         w_hs    = i_s_axi_wvalid & wready_q;
  wire         ar_hs   = i_s_axi_arvalid & arready_q;
  // Both halves held and no answer pending
  wire         wr_go   = ~awready_q & ~wready_q & ~bvalid_q;
  wire         wr_ok   = wr_go & mapped(aw_word_q);
  // Writes without the low byte lane store nothing
  wire         wr_en   = wr_ok & wlane_q;
  wire [8:0]   ar_word = word_of(i_s_axi_araddr);
  wire         rd_ok   = mapped(ar_word);
  wire [7:0]   wb      = wbyte_q;

  function automatic logic hit(input logic [7:0] ix);
    return wr_en && aw_word_q[7:0] == ix;
  endfunction

  // ==========================================
  // Event sources
  // Flag rises on any comparator output change while enabled
  wire [1:0]   cmp_edge;
  for (genvar i = 0; i < 2; i++) begin : g_cmp_edge
    assign cmp_edge[i] = (cmp_s2_q[i] ^ cmp_prev_q[i])
                       & cmp_q[i][`CMP_EN_BIT];
  end
  // Flash operation finished when busy falls
  wire         flash_done = fstat_q.busy & ~i_flash_status.busy;
  wire [2:0]   events     = {flash_done, cmp_edge};
  wire         rd_stat    = ar_hs & rd_ok
                          & ar_word[7:0] == `IX_IRQ_STATUS;

  // Read clears, but a new event in the same cycle survives
  assign irq_stat_d = (irq_stat_q & ~{3{rd_stat}}) | events;

  // Status view; reserved middle bits read as ones
  wire [7:0]   flash_rd = {fstat_q.busy, `FLASH_STAT_FILL,
                           fstat_q.high_voltage_abort_flag,
                           fstat_q.high_voltage_error_flag,
                           fstat_q.security_violation_flag,
                           fstat_q.operation_interrupted_flag};

  // ==========================================
  // Read selection
  logic [7:0]  rd_byte;
  always_comb begin
    rd_byte = `RST_ZERO;
    case (ar_word[7:0])
      `IX_DATA_PTR_LO:  rd_byte = ptr_lo_q;
      `IX_DATA_PTR_HI:  rd_byte = ptr_hi_q;
      `IX_CLOCK_DIV:    rd_byte = clk_div_q;
      `IX_AUX_CTL:      rd_byte = aux_q & `MASK_AUX;
      `IX_CMP_ONE:      rd_byte = {cmp_q[0][7:2],
                                   cmp_s2_q[0], cmp_q[0][0]};
      `IX_CMP_TWO:      rd_byte = {cmp_q[1][7:2],
                                   cmp_s2_q[1], cmp_q[1][0]};
      `IX_BAUD_CTL:     rd_byte = baud_ctl_q;
      `IX_BAUD_LO:      rd_byte = baud_lo_q;
      `IX_BAUD_HI:      rd_byte = baud_hi_q;
      `IX_SBUS_CTL:     rd_byte = sbus_ctl_q;
      `IX_SBUS_DATA:    rd_byte = sbus_data_q;
      `IX_SBUS_ADDR:    rd_byte = sbus_addr_q;
      `IX_ACCUM:        rd_byte = accum_q;
      `IX_FLASH_CTL:    rd_byte = flash_rd;
      `IX_FLASH_DATA:   rd_byte = fdata_q;
      `IX_FLASH_ADR_LO: rd_byte = fadr_lo_q;
      `IX_FLASH_ADR_HI: rd_byte = fadr_hi_q;
      `IX_SECOND_OP:    rd_byte = second_q;
      `IX_IRQ_STATUS:   rd_byte = {5'h00, irq_stat_q};
      `IX_IRQ_MASK:     rd_byte = {5'h00, irq_mask_q};
      default:          rd_byte = `RST_ZERO;
    endcase
  end

  // ==========================================
  // Write channel: address and data taken in either order
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      bvalid_q  <= 1'b0;
      bresp_q   <= `RESP_OKAY;
      aw_word_q <= 9'h000;
      wbyte_q   <= `RST_ZERO;
      wlane_q   <= 1'b0;
    end else begin
      if (aw_hs) begin
        awready_q <= 1'b0;
        aw_word_q <= word_of(i_s_axi_awaddr);
      end
      if (w_hs) begin
        wready_q <= 1'b0;
        wbyte_q  <= i_s_axi_wdata[7:0];
        wlane_q  <= i_s_axi_wstrb[0];
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        // Unmapped locations answer with an error
        bresp_q  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid_q && i_s_axi_bready) begin
        bvalid_q  <= 1'b0;
        awready_q <= 1'b1;
        wready_q  <= 1'b1;
      end
    end
  end

  // ==========================================
  // Read channel: data one cycle after the address is taken
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
      rresp_q   <= `RESP_OKAY;
      rbyte_q   <= `RST_ZERO;
    end else if (ar_hs) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rresp_q   <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      rbyte_q   <= rd_ok ? rd_byte : `RST_ZERO;
    end else if (rvalid_q && i_s_axi_rready) begin
      arready_q <= 1'b1;
      rvalid_q  <= 1'b0;
    end
  end

  // ==========================================
  // Plain byte registers
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      ptr_lo_q    <= `RST_ZERO;
      ptr_hi_q    <= `RST_ZERO;
      clk_div_q   <= `RST_ZERO;
      baud_lo_q   <= `RST_ZERO;
      baud_hi_q   <= `RST_ZERO;
      sbus_data_q <= `RST_ZERO;
      sbus_addr_q <= `RST_ZERO;
      accum_q     <= `RST_ZERO;
      fdata_q     <= `RST_ZERO;
      fadr_lo_q   <= `RST_ZERO;
      second_q    <= `RST_ZERO;
    end else begin
      if (hit(`IX_DATA_PTR_LO))  ptr_lo_q    <= wb;
      if (hit(`IX_DATA_PTR_HI))  ptr_hi_q    <= wb;
      if (hit(`IX_CLOCK_DIV))    clk_div_q   <= wb;
      if (hit(`IX_BAUD_LO))      baud_lo_q   <= wb;
      if (hit(`IX_BAUD_HI))      baud_hi_q   <= wb;
      if (hit(`IX_SBUS_DATA))    sbus_data_q <= wb;
      if (hit(`IX_SBUS_ADDR))    sbus_addr_q <= wb;
      if (hit(`IX_ACCUM))        accum_q     <= wb;
      if (hit(`IX_FLASH_DATA))   fdata_q     <= wb;
      if (hit(`IX_FLASH_ADR_LO)) fadr_lo_q   <= wb;
      if (hit(`IX_SECOND_OP))    second_q    <= wb;
    end
  end

  // ==========================================
  // Masked registers: reserved and fixed bits never stored
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      aux_q      <= `RST_ZERO;
      baud_ctl_q <= `RST_ZERO;
      sbus_ctl_q <= `RST_ZERO;
      fadr_hi_q  <= `RST_ZERO;
      irq_mask_q <= 3'h0;
    end else begin
      if (hit(`IX_AUX_CTL))
        aux_q <= wb & `MASK_AUX;
      if (hit(`IX_BAUD_CTL))
        baud_ctl_q <= wb & `MASK_BAUD_CTL;
      if (hit(`IX_SBUS_CTL))
        sbus_ctl_q <= wb & `MASK_SBUS_CTL;
      if (hit(`IX_FLASH_ADR_HI))
        fadr_hi_q <= wb & `MASK_FLASH_ADR_HI;
      if (hit(`IX_IRQ_MASK))
        irq_mask_q <= wb[2:0];
    end
  end

  // ==========================================
  // Comparator controls; a hardware flag set beats a write
  for (genvar i = 0; i < 2; i++) begin : g_cmp
    wire [7:0] ix = (i == 0) ? `IX_CMP_ONE : `IX_CMP_TWO;
    // Compare written out: a continuous assignment only wakes on its
    // operands, so a function reading wr_en would never update here
    wire       we = wr_en && aw_word_q[7:0] == ix;
    always_ff @(posedge i_clk) begin
      if (!i_reset_n) begin
        cmp_q[i] <= `RST_ZERO;
      end else begin
        if (we)
          cmp_q[i][7:1] <= wb[7:1] & 7'(`MASK_CMP >> 1);
        cmp_q[i][`CMP_FLAG_BIT] <= cmp_edge[i]
          | (we ? wb[`CMP_FLAG_BIT] : cmp_q[i][`CMP_FLAG_BIT]);
      end
    end
  end

  // ==========================================
  // Two-stage synchroniser; only stage two feeds logic
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      cmp_s1_q   <= 2'h0;
      cmp_s2_q   <= 2'h0;
      cmp_prev_q <= 2'h0;
    end else begin
      cmp_s1_q   <= i_cmp_level;
      cmp_s2_q   <= cmp_s1_q;
      cmp_prev_q <= cmp_s2_q;
    end
  end

  // ==========================================
  // Flash command path; status comes only from the engine
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      fstat_q <= '0;
      fcmd_q  <= '0;
    end else begin
      fstat_q <= i_flash_status;
      fcmd_q.valid <= hit(`IX_FLASH_CTL);
      if (hit(`IX_FLASH_CTL)) begin
        fcmd_q.flash_command_code <= wb;
        fcmd_q.address <= {fadr_hi_q[1:0], fadr_lo_q};
        fcmd_q.data    <= fdata_q;
      end
    end
  end

  // ==========================================
  // Interrupt status and level output
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      irq_stat_q <= 3'h0;
      irq_q      <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_q      <= |(irq_stat_d & irq_mask_q);
    end
  end

  // ==========================================
  // Outputs, all straight from flip-flops
  assign o_s_axi_awready = awready_q;
  assign o_s_axi_wready  = wready_q;
  assign o_s_axi_bvalid  = bvalid_q;
  assign o_s_axi_bresp   = bresp_q;
  assign o_s_axi_arready = arready_q;
  assign o_s_axi_rvalid  = rvalid_q;
  assign o_s_axi_rresp   = rresp_q;
  assign o_s_axi_rdata   = {24'h000000, rbyte_q};
  assign o_flash_cmd     = fcmd_q;
  assign o_irq           = irq_q;
  assign o_ctrl = '{
    data_pointer_word:      {ptr_hi_q, ptr_lo_q},
    cpu_clock_divider:      clk_div_q,
    auxiliary_control:      aux_q,
    comparator_one_control: cmp_q[0],
    comparator_two_control: cmp_q[1],
    baud_generator_control: baud_ctl_q[1:0],
    baud_divisor:           {baud_hi_q, baud_lo_q},
    serial_bus_control:     sbus_ctl_q,
    serial_bus_data:        sbus_data_q,
    serial_bus_own_address: sbus_addr_q,
    accumulator:            accum_q,
    second_operand:         second_q};

  // ==========================================
  // Checks
  // Antecedents use plain signals so they are sampled like the rest
  wire ar_flash = ar_hs & ar_word == {1'b1, `IX_FLASH_CTL};
  wire ar_aux   = ar_hs & ar_word == {1'b1, `IX_AUX_CTL};

  chk_flash_read: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    ar_flash |=> o_s_axi_rvalid
      && o_s_axi_rdata[7:0] == $past(flash_rd)
      && o_s_axi_rdata[6:4] == `FLASH_STAT_FILL)
    else $error("flash status read wrong");

  chk_flash_cmd: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    wr_en && aw_word_q[7:0] == `IX_FLASH_CTL |=> o_flash_cmd.valid
      && o_flash_cmd.flash_command_code == $past(wbyte_q)
      && o_flash_cmd.address == $past({fadr_hi_q[1:0], fadr_lo_q}))
    else $error("flash command not issued");

  chk_aux_zero: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    ar_aux |=> o_s_axi_rdata[`AUX_ZERO_BIT] == 1'b0
      && o_s_axi_rdata[31:8] == 24'h000000)
    else $error("fixed zero bit read one");

  chk_adr_high_bits: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    wr_en && aw_word_q[7:0] == `IX_FLASH_ADR_HI
      |=> fadr_hi_q[7:2] == 6'h00
      && fadr_hi_q[1:0] == $past(wbyte_q[1:0]))
    else $error("flash address high wrong");

  chk_baud_ctl: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    wr_en && aw_word_q[7:0] == `IX_BAUD_CTL
      |=> o_ctrl.baud_generator_control
      == $past(wbyte_q[1:0]))
    else $error("baud control not loaded");

  chk_cmp_flag_set: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    cmp_edge[0] |=> cmp_q[0][`CMP_FLAG_BIT]
      && (o_irq || !$past(irq_mask_q[0])))
    else $error("comparator flag lost");

  chk_clock_div: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    wr_en && aw_word_q[7:0] == `IX_CLOCK_DIV
      |=> o_ctrl.cpu_clock_divider
      == $past(wbyte_q))
    else $error("clock divider not loaded");

  chk_own_address: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    wr_en && aw_word_q[7:0] == `IX_SBUS_ADDR
      |=> o_ctrl.serial_bus_own_address
      == $past(wbyte_q))
    else $error("own address not loaded");

  chk_reset_values: assert property (
    @(posedge i_clk)
    !i_reset_n |=> flash_rd == `RST_FLASH_STAT
      && o_ctrl == '0 && !o_irq)
    else $error("reset values wrong");

  cov_write: cover property (
    @(posedge i_clk) disable iff (!i_reset_n)
    wr_en ##1 o_s_axi_bvalid);
  cov_flash_read: cover property (
    @(posedge i_clk) disable iff (!i_reset_n) ar_flash);
  cov_irq: cover property (
    @(posedge i_clk) disable iff (!i_reset_n) $rose(o_irq));

endmodule

/* File: shared/sfr_map_params.svh */
/*
  Register indices, field positions, writable masks and reset values
  of the special register slice. Assumes byte address = 4 * index.
*/
`ifndef SFR_MAP_PARAMS_SVH
`define SFR_MAP_PARAMS_SVH
// ==========================================
// Register indices
`define IX_DATA_PTR_LO   8'h82
`define IX_DATA_PTR_HI   8'h83
`define IX_CLOCK_DIV     8'h95
`define IX_AUX_CTL       8'ha2
`define IX_CMP_ONE       8'hac
`define IX_CMP_TWO       8'had
`define IX_BAUD_CTL      8'hbd
`define IX_BAUD_LO       8'hbe
`define IX_BAUD_HI       8'hbf
`define IX_SBUS_CTL      8'hd8
`define IX_SBUS_DATA     8'hda
`define IX_SBUS_ADDR     8'hdb
`define IX_ACCUM         8'he0
`define IX_FLASH_CTL     8'he4
`define IX_FLASH_DATA    8'he5
`define IX_FLASH_ADR_LO  8'he6
`define IX_FLASH_ADR_HI  8'he7
`define IX_SECOND_OP     8'hf0
`define IX_IRQ_STATUS    8'h40
`define IX_IRQ_MASK      8'h41
// ==========================================
// Field positions
`define CMP_OUT_BIT      1
`define CMP_FLAG_BIT     0
`define CMP_EN_BIT       5
`define AUX_ZERO_BIT     2
// ==========================================
// Writable masks, reserved bits read zero
`define MASK_AUX         8'hf9
`define MASK_CMP         8'h3d
`define MASK_BAUD_CTL    8'h03
`define MASK_SBUS_CTL    8'h7d
`define MASK_FLASH_ADR_HI 8'h03
`define MASK_IRQ         8'h07
// ==========================================
// Reset values, status fill and bus response codes
`define RST_ZERO         8'h00
`define FLASH_STAT_FILL  3'h7
`define RST_FLASH_STAT   8'h70
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

/* File: shared/sfr_map_pkg.sv */
/*
  Types of the special register slice.
  Assumes the params header supplies all numbers.
*/
package sfr_map_pkg;
  // Flash engine status, same clock as the bank
  typedef struct packed {
    logic       busy;
    logic       high_voltage_abort_flag;
    logic       high_voltage_error_flag;
    logic       security_violation_flag;
    logic       operation_interrupted_flag;
  } flash_status_t;
  // One-cycle command to the flash engine
  typedef struct packed {
    logic       valid;
    logic [7:0] flash_command_code;
    logic [9:0] address;
    logic [7:0] data;
  } flash_cmd_t;
  // Control values seen by the rest of the chip
  typedef struct packed {
    logic [15:0] data_pointer_word;
    logic [7:0]  cpu_clock_divider;
    logic [7:0]  auxiliary_control;
    logic [7:0]  comparator_one_control;
    logic [7:0]  comparator_two_control;
    logic [1:0]  baud_generator_control;
    logic [15:0] baud_divisor;
    logic [7:0]  serial_bus_control;
    logic [7:0]  serial_bus_data;
    logic [7:0]  serial_bus_own_address;
    logic [7:0]  accumulator;
    logic [7:0]  second_operand;
  } sfr_ctrl_t;
endpackage

/* File: testbench/sfr_map_slice_tb.sv */
/*
  Self-checking bench for the special register slice over AXI4-Lite.
  Assumes the params header on the include path and one 40 MHz clock.
*/
`timescale 1ns/100ps
`include "sfr_map_params.svh"

module sfr_map_slice_tb;
  // ==========================================
  // Clock, reset and design ports
  logic                       i_clk     = 1'b0;
  logic                       i_reset_n = 1'b0;
  logic                       awvalid   = 1'b0;
  logic                       wvalid    = 1'b0;
  logic                       bready    = 1'b0;
  logic                       arvalid   = 1'b0;
  logic                       rready    = 1'b0;
  logic [11:0]                awaddr    = 12'h000;
  logic [11:0]                araddr    = 12'h000;
  logic [31:0]                wdata     = 32'h00000000;
  logic [1:0]                 cmp       = 2'h0;
  sfr_map_pkg::flash_status_t fs        = 5'h00;
  sfr_map_pkg::flash_cmd_t    fcmd;
  sfr_map_pkg::sfr_ctrl_t     ctrl;
  logic                       awrdy, wrdy, bvalid, arrdy, rvalid, irq;
  logic [1:0]                 bresp, rresp, rs;
  logic [31:0]                rdata;
  logic [7:0]                 rd;
  int                         err_count   = 0;
  int                         checks_done = 0;
  int                         cycles      = 0;
  logic [7:0] rst_ix [18] = '{`IX_DATA_PTR_LO, `IX_DATA_PTR_HI,
    `IX_CLOCK_DIV, `IX_AUX_CTL, `IX_CMP_ONE, `IX_CMP_TWO, `IX_BAUD_CTL,
    `IX_BAUD_LO, `IX_BAUD_HI, `IX_SBUS_CTL, `IX_SBUS_DATA, `IX_SBUS_ADDR,
    `IX_ACCUM, `IX_FLASH_DATA, `IX_FLASH_ADR_LO, `IX_FLASH_ADR_HI,
    `IX_SECOND_OP, `IX_IRQ_MASK};
  logic [7:0] rw_ix [7] = '{`IX_CLOCK_DIV, `IX_BAUD_LO, `IX_BAUD_HI,
    `IX_ACCUM, `IX_SECOND_OP, `IX_SBUS_DATA, `IX_FLASH_ADR_LO};

  // Half period of 12.5 ns gives 40 MHz
  always #12.5 i_clk = ~i_clk;

  sfr_map_slice sfr_map_slice_i (
    .i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awrdy),
    .i_s_axi_awaddr(awaddr), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wrdy), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(4'h1), .o_s_axi_bvalid(bvalid),
    .i_s_axi_bready(bready), .o_s_axi_bresp(bresp),
    .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arrdy),
    .i_s_axi_araddr(araddr), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .o_s_axi_rdata(rdata),
    .o_s_axi_rresp(rresp), .i_cmp_level(cmp), .i_flash_status(fs),
    .o_flash_cmd(fcmd), .o_ctrl(ctrl), .o_irq(irq)
  );

  // ==========================================
  // Reporting
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      wrap_up();
    end
  end

  // ==========================================
  // Bus tasks; each starts one edge later so no strobe is set twice
  task automatic wr(input logic [7:0] ix, input logic [7:0] d,
                    output logic [1:0] r);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    @(posedge i_clk);
    awaddr  <= {2'h0, ix, 2'h0};
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge i_clk);
      if (awvalid && awrdy) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wrdy) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end while (!(aw_ok && w_ok));
    do @(posedge i_clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] ix, output logic [7:0] d,
                        output logic [1:0] r);
    @(posedge i_clk);
    araddr  <= {2'h0, ix, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge i_clk);
      if (arvalid && arrdy) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata[7:0];
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic put(input logic [7:0] ix, input logic [7:0] d);
    wr(ix, d, rs);
    check("write response", rs, `RESP_OKAY);
  endtask

  // Response and data compared together in one word
  task automatic rd_chk(input string what, input logic [7:0] ix,
                        input logic [7:0] exp);
    rd_reg(ix, rd, rs);
    check(what, {22'h0, rs, rd}, {22'h0, `RESP_OKAY, exp});
  endtask

  // Bounded wait; the event path has a few flops of latency
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 8) begin
      @(posedge i_clk);
      n++;
    end
  endtask

  // ==========================================
  // Main sequence
  initial begin
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    foreach (rst_ix[k]) rd_chk("reset value", rst_ix[k], 8'h00);
    rd_chk("flash status reset", `IX_FLASH_CTL, `RST_FLASH_STAT);
    foreach (rw_ix[k]) begin
      put(rw_ix[k], 8'h5a ^ 8'(k));
      rd_chk("byte readback", rw_ix[k], 8'h5a ^ 8'(k));
    end
    put(`IX_DATA_PTR_HI, 8'h12);
    put(`IX_DATA_PTR_LO, 8'h34);
    check("pointer word", ctrl.data_pointer_word, 16'h1234);
    put(`IX_SBUS_ADDR, 8'ha5);
    check("own address", ctrl.serial_bus_own_address, 8'ha5);
    rd_chk("own address", `IX_SBUS_ADDR, 8'ha5);
    put(`IX_BAUD_CTL, 8'hff);
    rd_chk("baud control", `IX_BAUD_CTL, 8'h03);
    check("baud bits", ctrl.baud_generator_control, 2'h3);
    // Reset request bit kept clear so the bank is not reset mid-run
    put(`IX_AUX_CTL, 8'hf7);
    rd_chk("aux control", `IX_AUX_CTL, 8'hf1);
    put(`IX_CMP_TWO, 8'hff);
    rd_chk("comparator two", `IX_CMP_TWO, 8'h3d);
    put(`IX_SBUS_CTL, 8'hff);
    rd_chk("serial control", `IX_SBUS_CTL, 8'h7d);
    rd_reg(8'h00, rd, rs);
    check("unmapped read", {rs, rd}, {`RESP_SLVERR, 8'h00});
    wr(8'h01, 8'hff, rs);
    check("unmapped write", rs, `RESP_SLVERR);
    put(`IX_FLASH_ADR_HI, 8'hff);
    rd_chk("flash address high", `IX_FLASH_ADR_HI, 8'h03);
    put(`IX_FLASH_ADR_LO, 8'h9c);
    put(`IX_FLASH_DATA, 8'h66);
    put(`IX_FLASH_CTL, 8'hc3);
    check("flash command", {fcmd.valid, fcmd.flash_command_code,
      fcmd.address, fcmd.data}, {1'b1, 8'hc3, 10'h39c, 8'h66});
    rd_chk("status after command", `IX_FLASH_CTL, 8'h70);
    // Comparator one edge raises its flag and the interrupt
    put(`IX_IRQ_MASK, 8'h07);
    rd_reg(`IX_IRQ_STATUS, rd, rs);
    put(`IX_CMP_ONE, 8'h20);
    cmp <= 2'h1;
    wait_irq();
    check("comparator irq", irq, 1'b1);
    rd_chk("comparator one", `IX_CMP_ONE, 8'h23);
    rd_chk("event status", `IX_IRQ_STATUS, 8'h01);
    check("irq after clear", irq, 1'b0);
    // Flash completion with its event masked off
    put(`IX_IRQ_MASK, 8'h03);
    fs <= 5'h18;
    rd_chk("flash busy status", `IX_FLASH_CTL, 8'hf8);
    fs <= 5'h00;
    repeat (4) @(posedge i_clk);
    check("masked irq", irq, 1'b0);
    rd_chk("flash done status", `IX_IRQ_STATUS, 8'h04);
    rd_chk("status cleared", `IX_IRQ_STATUS, 8'h00);
    wrap_up();
  end
endmodule
